// *** design/sac_consts.vh ***
// Contract
// - Conversion busy lasts at most 560 ns outside after-convert mode.
// - Busy rises within 23 ns of start.
// - Busy falls 10 ns after conversion end, except in after-convert mode.
// - Reset release gives busy for 600 ns.
// - Parallel result valid before busy falls.
// - Bus drives data on request, releases after.
// - Master serial pins follow chip select.
// - Read-during-convert frame starts after 263 ns.
// - Read-during-convert clock uses fastest rate.
// - Divider code selects after-convert clock period.
// - After-convert busy bounded per divider code.
// - Frame held past last serial clock edge.
// - After-convert frame drops one cycle before busy.
// - Slave data updates after external clock edge.
// - Result available at conversion end, no latency.
// - Divider honoured only in after-convert mode.
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// ****************************************************************
// Clock and conversions from time to cycles
// ****************************************************************
`define SAC_CLK_NS           10
`define SAC_CEIL_CYC(ns)     (((ns) + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_FLOOR_CYC(ns)    ((ns) / `SAC_CLK_NS)

// ****************************************************************
// Conversion and reset timing
// ****************************************************************
`define SAC_T_SPACING_NS     750
`define SAC_T_CONV_NS        400
`define SAC_T_RESET_BUSY_NS  600
`define SAC_T_SYNC_DLY_NS    263
`define SAC_SPACING_CYC      `SAC_CEIL_CYC(`SAC_T_SPACING_NS)
`define SAC_CONV_CYC         `SAC_FLOOR_CYC(`SAC_T_CONV_NS)
`define SAC_RESET_CYC        (`SAC_FLOOR_CYC(`SAC_T_RESET_BUSY_NS) - 1)
`define SAC_SYNC_CYC         (`SAC_FLOOR_CYC(`SAC_T_SYNC_DLY_NS) - 1)

// ****************************************************************
// Longest serial clock period for each divider code
// ****************************************************************
`define SAC_T_SCLK_MAX0_NS   12
`define SAC_T_SCLK_MAX1_NS   25
`define SAC_T_SCLK_MAX2_NS   50
`define SAC_T_SCLK_MAX3_NS   100
`define SAC_DIV_CODE0        2'h0
`define SAC_DIV_CODE1        2'h1
`define SAC_DIV_CODE2        2'h2

// ****************************************************************
// Data word
// ****************************************************************
`define SAC_WORD_BITS        16
`define SAC_MSB              15
`define SAC_HALF_BITS        4

`endif

// *** design/sac_timer.v ***
`timescale 1ns/1ps
`default_nettype none
module sac_timer #(
   parameter W = 8
) (
   input  wire         sys_clk,
   input  wire         nrst,
   input  wire         clkEn,
   input  wire         cancel,
   input  wire         load,
   input  wire [W-1:0] loadValue,
   output reg          expiredReg
);
   localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
   reg [W-1:0] countReg;
   reg         runningReg;

   always @(posedge sys_clk) begin
      if (!nrst) begin
         countReg   <= {W{1'b0}};
         runningReg <= 1'b0;
         expiredReg <= 1'b0;
      end else if (clkEn) begin
         expiredReg <= 1'b0;
         if (cancel) begin
            runningReg <= 1'b0;
         end else if (load) begin
            countReg   <= loadValue;
            runningReg <= 1'b1;
         end else if (runningReg) begin
            if (countReg == ONE) begin
               expiredReg <= 1'b1;
               runningReg <= 1'b0;
            end
            countReg <= countReg - ONE;
         end
      end
   end
endmodule // sac_timer
`default_nettype wire

// *** design/sac_serial.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
module sac_serial #(
   parameter WORD = `SAC_WORD_BITS,
   parameter HW   = `SAC_HALF_BITS
) (
   input  wire          sys_clk,
   input  wire          nrst,
   input  wire          clkEn,
   input  wire          abort,
   input  wire          loadWord,
   input  wire [WORD-1:0] word,
   input  wire          startFrame,
   input  wire [HW-1:0] halfCycles,
   input  wire          slaveMode,
   input  wire          extEdge,
   input  wire          serialIn,
   output reg           sclkReg,
   output reg           sdoReg,
   output reg           frameReg,
   output reg           doneReg
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_RUN  = 2'h1;
   localparam [1:0] ST_TAIL = 2'h2;
   localparam [HW-1:0] HONE = {{(HW-1){1'b0}}, 1'b1};
   localparam integer LAST_BIT = `SAC_MSB;

   reg [1:0]      stateReg;
   reg [WORD-1:0] shiftReg;
   reg [HW-1:0]   halfReg;
   reg [HW-1:0]   halfLoadReg;
   reg [4:0]      bitReg;

   always @(posedge sys_clk) begin
      if (!nrst) begin
         stateReg    <= ST_IDLE;
         shiftReg    <= {WORD{1'b0}};
         halfReg     <= {HW{1'b0}};
         halfLoadReg <= HONE;
         bitReg      <= 5'h0;
         sclkReg     <= 1'b0;
         sdoReg      <= 1'b0;
         frameReg    <= 1'b0;
         doneReg     <= 1'b0;
      end else if (clkEn) begin
         doneReg <= 1'b0;
         if (abort) begin
            stateReg <= ST_IDLE;
            sclkReg  <= 1'b0;
            frameReg <= 1'b0;
         end else if (loadWord) begin
            shiftReg <= word;
            sdoReg   <= word[WORD-1];
         end else if (slaveMode && extEdge) begin
            shiftReg <= {shiftReg[WORD-2:0], serialIn};
            sdoReg   <= shiftReg[WORD-2];
         end else begin
            case (stateReg)
               ST_IDLE: begin
                  if (startFrame && !slaveMode) begin
                     stateReg    <= ST_RUN;
                     frameReg    <= 1'b1;
                     halfReg     <= halfCycles;
                     halfLoadReg <= halfCycles;
                     bitReg      <= LAST_BIT[4:0];
                  end
               end
               ST_RUN: begin
                  if (halfReg == HONE) begin
                     halfReg <= halfLoadReg;
                     sclkReg <= ~sclkReg;
                     if (sclkReg) begin
                        if (bitReg == 5'h0) begin
                           stateReg <= ST_TAIL;
                        end else begin
                           shiftReg <= {shiftReg[WORD-2:0], serialIn};
                           sdoReg   <= shiftReg[WORD-2];
                           bitReg   <= bitReg - 5'h1;
                        end
                     end
                  end else begin
                     halfReg <= halfReg - HONE;
                  end
               end
               ST_TAIL: begin
                  if (halfReg == HONE) begin
                     frameReg <= 1'b0;
                     doneReg  <= 1'b1;
                     stateReg <= ST_IDLE;
                  end else begin
                     halfReg <= halfReg - HONE;
                  end
               end
               default: begin
                  stateReg <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // sac_serial
`default_nettype wire

// *** design/sac_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
module sac_top #(
   parameter WORD = `SAC_WORD_BITS,
   parameter TW   = 8,
   parameter HW   = `SAC_HALF_BITS
) (
   input  wire            sys_clk,
   input  wire            nrst,
   input  wire            clkEn,
   input  wire            convStartN,
   input  wire            resetIn,
   input  wire            chipSelN,
   input  wire            readN,
   input  wire            serialMode,
   input  wire            extClockMode,
   input  wire            readDuringConv,
   input  wire            straightBinary,
   input  wire [1:0]      serialClockDivider,
   input  wire [WORD-1:0] adcSample,
   input  wire            extSerialClk,
   input  wire            serialDataIn,
   output reg             busyReg,
   output reg  [WORD-1:0] dataBusReg,
   output reg             dataBusOeReg,
   output wire            frameSync,
   output reg             frameSyncOeReg,
   output wire            serialClk,
   output reg             serialClkOeReg,
   output wire            serialDataOut,
   output reg             serialDataOeReg,
   output reg  [1:0]      serialClockDividerOutReg,
   output reg             serialClockDividerOeReg
);
   // ****************************************************************
   // States and loads
   // ****************************************************************
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_RESET = 3'h1;
   localparam [2:0] ST_CONV  = 3'h2;
   localparam [2:0] ST_EOC   = 3'h3;
   localparam [2:0] ST_READ  = 3'h4;

   localparam integer SPACING_LOAD = `SAC_SPACING_CYC;
   localparam integer CONV_LOAD    = `SAC_CONV_CYC;
   localparam integer RESET_LOAD   = `SAC_RESET_CYC;
   localparam integer SYNC_LOAD    = `SAC_SYNC_CYC;

   // ****************************************************************
   // Functions
   // ****************************************************************
   function sacRise;
      input prevLevel;
      input curLevel;
      begin
         sacRise = curLevel & ~prevLevel;
      end
   endfunction

   // A half period never goes below one cycle, so the fastest code runs
   // at twice the clock period, slower than its allowed maximum.
   // code sets half period
   function [HW-1:0] sacHalf;
      input [1:0] code;
      integer cyc;
      begin
         cyc = 0;
         if (code == `SAC_DIV_CODE0) begin
            cyc = `SAC_FLOOR_CYC(`SAC_T_SCLK_MAX0_NS) / 2;
         end else if (code == `SAC_DIV_CODE1) begin
            cyc = `SAC_FLOOR_CYC(`SAC_T_SCLK_MAX1_NS) / 2;
         end else if (code == `SAC_DIV_CODE2) begin
            cyc = `SAC_FLOOR_CYC(`SAC_T_SCLK_MAX2_NS) / 2;
         end else begin
            cyc = `SAC_FLOOR_CYC(`SAC_T_SCLK_MAX3_NS) / 2;
         end

         if (cyc < 1) begin
            cyc = 1;
         end

         sacHalf = cyc[HW-1:0];
      end
   endfunction

   function [WORD-1:0] sacFormat;
      input [WORD-1:0] sample;
      input            straight;
      begin
         sacFormat = {sample[WORD-1] ^ ~straight, sample[WORD-2:0]};
      end
   endfunction

   // ****************************************************************
   // Edge detection and mode decode
   // ****************************************************************
   reg [2:0]      stateReg;
   reg            startPrevReg;
   reg            resetPrevReg;
   reg            extClkPrevReg;
   reg            spacingBusyReg;
   reg [WORD-1:0] resultReg;

   wire busyTimerDone;
   wire spacingDone;
   wire syncDone;
   wire serialDone;

   wire masterMode = serialMode & ~extClockMode;
   wire slaveMode  = serialMode & extClockMode;
   wire afterConv  = masterMode & ~readDuringConv;
   wire duringConv = masterMode & readDuringConv;

   wire startFell  = sacRise(~startPrevReg, ~convStartN);
   wire resetFell  = sacRise(~resetPrevReg, ~resetIn);
   wire extClkRose = sacRise(extClkPrevReg, extSerialClk);

   wire startOk = startFell & (stateReg == ST_IDLE) & ~spacingBusyReg &
                  ~resetIn & ~resetFell;

   wire captureNow = (stateReg == ST_CONV) & busyTimerDone;
   wire [WORD-1:0] coded = sacFormat(adcSample, straightBinary);

   // A capture must not cut into a frame that sends the old word.
   wire serialLoad = duringConv ? startOk : captureNow;

   wire [HW-1:0] halfSel = afterConv ? sacHalf(serialClockDivider) :
                                       sacHalf(`SAC_DIV_CODE0);

   // ****************************************************************
   // Timers
   // ****************************************************************
   sac_timer #(.W(TW)) busyTimer (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .clkEn      (clkEn),
      .cancel     (resetIn),
      .load       (startOk | resetFell),
      .loadValue  (resetFell ? RESET_LOAD[TW-1:0] : CONV_LOAD[TW-1:0]),
      .expiredReg (busyTimerDone)
   );

   sac_timer #(.W(TW)) spacingTimer (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .clkEn      (clkEn),
      .cancel     (resetIn),
      .load       (startOk),
      .loadValue  (SPACING_LOAD[TW-1:0]),
      .expiredReg (spacingDone)
   );

   sac_timer #(.W(TW)) syncTimer (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .clkEn      (clkEn),
      .cancel     (resetIn),
      .load       (startOk & duringConv),
      .loadValue  (SYNC_LOAD[TW-1:0]),
      .expiredReg (syncDone)
   );

   // ****************************************************************
   // Serial port
   // ****************************************************************
   // shared clock generator
   sac_serial #(.WORD(WORD), .HW(HW)) serialPort (
      .sys_clk    (sys_clk),
      .nrst       (nrst),
      .clkEn      (clkEn),
      .abort      (resetIn),
      .loadWord   (serialLoad),
      .word       (captureNow ? coded : resultReg),
      .startFrame (syncDone | ((stateReg == ST_EOC) & afterConv)),
      .halfCycles (halfSel),
      .slaveMode  (slaveMode),
      .extEdge    (extClkRose & ~chipSelN),
      .serialIn   (serialDataIn),
      .sclkReg    (serialClk),
      .sdoReg     (serialDataOut),
      .frameReg   (frameSync),
      .doneReg    (serialDone)
   );

   // ****************************************************************
   // Control and outputs
   // ****************************************************************
   always @(posedge sys_clk) begin
      if (!nrst) begin
         stateReg                 <= ST_IDLE;
         startPrevReg             <= 1'b1;
         resetPrevReg             <= 1'b0;
         extClkPrevReg            <= 1'b0;

         spacingBusyReg           <= 1'b0;
         resultReg                <= {WORD{1'b0}};

         busyReg                  <= 1'b0;
         dataBusReg               <= {WORD{1'b0}};
         dataBusOeReg             <= 1'b0;
         frameSyncOeReg           <= 1'b0;
         serialClkOeReg           <= 1'b0;
         serialDataOeReg          <= 1'b0;
         serialClockDividerOutReg <= 2'h0;
         serialClockDividerOeReg  <= 1'b0;
      end else if (clkEn) begin
         startPrevReg  <= convStartN;
         resetPrevReg  <= resetIn;
         extClkPrevReg <= extSerialClk;

         dataBusOeReg    <= ~serialMode & ~chipSelN & ~readN;

         frameSyncOeReg  <= masterMode & ~chipSelN;
         serialClkOeReg  <= masterMode & ~chipSelN;
         serialDataOeReg <= serialMode & ~chipSelN;

         serialClockDividerOeReg  <= 1'b0;
         serialClockDividerOutReg <= 2'h0;

         if (captureNow) begin
            resultReg  <= coded;
            dataBusReg <= coded;
         end else begin
            dataBusReg <= resultReg;
         end

         if (startOk) begin
            spacingBusyReg <= 1'b1;
         end else if (spacingDone || resetIn) begin
            spacingBusyReg <= 1'b0;
         end

         if (resetIn) begin
            stateReg <= ST_IDLE;
            busyReg  <= 1'b0;
         end else if (resetFell) begin
            stateReg <= ST_RESET;
            busyReg  <= 1'b1;
         end else begin
            case (stateReg)
               ST_IDLE: begin
                  if (startOk) begin
                     busyReg  <= 1'b1;
                     stateReg <= ST_CONV;
                  end
               end

               ST_RESET: begin
                  if (busyTimerDone) begin
                     busyReg  <= 1'b0;
                     stateReg <= ST_IDLE;
                  end
               end

               ST_CONV: begin
                  if (busyTimerDone) begin
                     stateReg <= ST_EOC;
                  end
               end

               ST_EOC: begin
                  if (afterConv) begin
                     stateReg <= ST_READ;
                  end else begin
                     busyReg  <= 1'b0;
                     stateReg <= ST_IDLE;
                  end
               end

               ST_READ: begin
                  // Busy waits one cycle behind the falling frame.
                  // frame then busy
                  if (serialDone) begin
                     busyReg  <= 1'b0;
                     stateReg <= ST_IDLE;
                  end
               end

               default: begin
                  stateReg <= ST_IDLE;
                  busyReg  <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // sac_top
`default_nettype wire

// *** testbench/sac_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Conversion and readout timing checker
// ****************************************************************
module sac_checker #(
   parameter WORD = 16
) (
   input wire logic            sys_clk,
   input wire logic            nrst,
   input wire logic            convStartN,
   input wire logic            resetIn,
   input wire logic            chipSelN,
   input wire logic            readN,
   input wire logic            serialMode,
   input wire logic            extClockMode,
   input wire logic            readDuringConv,
   input wire logic [1:0]      serialClockDivider,
   input wire logic            busyReg,
   input wire logic [WORD-1:0] dataBusReg,
   input wire logic            dataBusOeReg,
   input wire logic            frameSync,
   input wire logic            frameSyncOeReg,
   input wire logic            serialClk,
   input wire logic            serialClkOeReg,
   input wire logic            serialDataOeReg,
   input wire logic [1:0]      serialClockDividerOutReg,
   input wire logic            serialClockDividerOeReg
);
   logic [7:0] busyCnt;
   logic       rstBusy;
   logic       rstPrev;
   wire        master = serialMode && !extClockMode;
   wire        ac     = master && !readDuringConv;
   wire        rdReq  = !serialMode && !chipSelN && !readN;
   wire [7:0]  acLim  = serialClockDivider == 2'h0 ? 8'h4E :
                        serialClockDivider == 2'h1 ? 8'h64 :
                        serialClockDivider == 2'h2 ? 8'h90 : 8'hE8;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Busy run length, and whether the run came from the reset pin.
   always_ff @(posedge sys_clk) begin
      busyCnt <= busyReg ? busyCnt + 8'h01 : 8'h00;
      rstPrev <= resetIn;
      rstBusy <= nrst && (resetIn || (rstBusy && (busyReg || rstPrev)));
   end
   property p_busy_cause; $rose(busyReg) |-> ($past(convStartN, 2) &&
      !$past(convStartN)) || ($past(resetIn, 2) && !$past(resetIn));
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy rose without a start");
   property p_busy_max;
      busyReg && !ac && !rstBusy |-> busyCnt < 8'h38;
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("busy too long");
   property p_reset_busy;
      $fell(busyReg) && rstBusy |-> busyCnt inside {[8'h3A:8'h3E]};
   endproperty
   a_reset_busy: assert property (p_reset_busy)
      else $error("reset busy width wrong");
   property p_bus_oe; 1'b1 |=> dataBusOeReg == $past(rdReq); endproperty
   a_bus_oe: assert property (p_bus_oe)
      else $error("bus enable wrong");
   property p_serial_oe; 1'b1 |=> frameSyncOeReg == $past(master &&
      !chipSelN) && serialClkOeReg == $past(master && !chipSelN) &&
      serialDataOeReg == $past(serialMode && !chipSelN);
   endproperty
   a_serial_oe: assert property (p_serial_oe)
      else $error("serial enable wrong");
   property p_div_pins;
      !serialClockDividerOeReg && serialClockDividerOutReg == 2'h0;
   endproperty
   a_div_pins: assert property (p_div_pins)
      else $error("divider pins driven");
   property p_frame_busy; $fell(frameSync) && ac |=> $fell(busyReg);
   endproperty
   a_frame_busy: assert property (p_frame_busy)
      else $error("busy not after frame end");
   property p_clk_frame;
      $fell(frameSync) |-> !serialClk && !$past(serialClk);
   endproperty
   a_clk_frame: assert property (p_clk_frame)
      else $error("frame ended on clock high");
   property p_clk_div3; $rose(serialClk) && ac && serialClockDivider ==
      2'h3 |-> serialClk [*5] ##1 !serialClk;
   endproperty
   a_clk_div3: assert property (p_clk_div3)
      else $error("slow clock high phase wrong");
   property p_ac_busy; busyReg && ac && !rstBusy |-> busyCnt < acLim;
   endproperty
   a_ac_busy: assert property (p_ac_busy)
      else $error("after convert busy too long");
   property p_sync_delay; $rose(busyReg) && master && readDuringConv &&
      !rstBusy |-> ##26 $rose(frameSync);
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("frame start delay wrong");
   c_reset: cover property ($fell(busyReg) && rstBusy);
   c_frame: cover property ($fell(frameSync) && ac);
   c_bus: cover property ($rose(dataBusOeReg));
endmodule // sac_checker
`default_nettype wire

// *** testbench/sac_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host controller model
// ****************************************************************
module sac_host_model (
   input  wire logic        sys_clk,
   input  wire logic        busyReg,
   input  wire logic        frameSync,
   input  wire logic        serialClk,
   input  wire logic        serialClkOeReg,
   input  wire logic        serialDataOut,
   input  wire logic        serialDataOeReg,
   output var  logic        convStartN,
   output var  logic        extSerialClk,
   output var  logic [15:0] rxWord
);
   // A released line reads inverted, never stale.
   wire sdoSeen = serialDataOeReg ? serialDataOut : ~serialDataOut;
   initial begin
      convStartN   = 1'b1;
      extSerialClk = 1'b0;
      rxWord       = 16'h0000;
   end
   always @(posedge serialClk) begin
      if (serialClkOeReg && frameSync) begin
         rxWord = {rxWord[14:0], sdoSeen};
      end
   end
   task automatic pulse();
      @(negedge sys_clk) convStartN = 1'b0;
      @(negedge sys_clk) convStartN = 1'b1;
   endtask
   task automatic conv(input int gap, output int width);
      pulse();
      width = 0;
      while (busyReg === 1'b1 && width < 300) begin
         width++;
         @(negedge sys_clk);
      end
      repeat (gap - width) @(negedge sys_clk);
   endtask
   // clock of 50 ns, still between frames.
   task automatic slave_read(output logic [15:0] word);
      for (int i = 0; i < 16; i++) begin
         @(negedge sys_clk);
         word = {word[14:0], sdoSeen};
         extSerialClk = 1'b1;
         repeat (2) @(negedge sys_clk);
         extSerialClk = 1'b0;
         repeat (2) @(negedge sys_clk);
      end
   endtask
endmodule // sac_host_model
`default_nettype wire

// *** testbench/sac_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Converter testbench
// ****************************************************************
module sac_top_tb_top;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        resetIn = 1'b0;
   logic        chipSelN = 1'b1;
   logic        readN = 1'b1;
   logic        serialMode = 1'b0;
   logic        extClockMode = 1'b0;
   logic        readDuringConv = 1'b0;
   logic        straightBinary = 1'b1;
   logic [1:0]  serialClockDivider = 2'h0;
   logic [15:0] adcSample = 16'h0000;
   logic        serialDataIn = 1'b0;
   logic [15:0] smp;
   logic [15:0] prev;
   logic [15:0] word;
   wire         convStartN;
   wire         extSerialClk;
   wire         busyReg;
   wire  [15:0] dataBusReg;
   wire         dataBusOeReg;
   wire         frameSync;
   wire         frameSyncOeReg;
   wire         serialClk;
   wire         serialClkOeReg;
   wire         serialDataOut;
   wire         serialDataOeReg;
   wire  [15:0] word_rx;
   int          seed;
   int          width;
   int          cycles = 0;
   int          err_total = 0;
   int          checked = 0;
   always #5 sys_clk = ~sys_clk;
   sac_top i_sac_top (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1),
      .convStartN(convStartN), .resetIn(resetIn), .chipSelN(chipSelN),
      .readN(readN), .serialMode(serialMode), .extClockMode(extClockMode),
      .readDuringConv(readDuringConv), .straightBinary(straightBinary),
      .serialClockDivider(serialClockDivider), .adcSample(adcSample),
      .extSerialClk(extSerialClk), .serialDataIn(serialDataIn),
      .busyReg(busyReg), .dataBusReg(dataBusReg),
      .dataBusOeReg(dataBusOeReg), .frameSync(frameSync),
      .frameSyncOeReg(frameSyncOeReg), .serialClk(serialClk),
      .serialClkOeReg(serialClkOeReg), .serialDataOut(serialDataOut),
      .serialDataOeReg(serialDataOeReg), .serialClockDividerOutReg(),
      .serialClockDividerOeReg());
   sac_host_model i_sac_host_model (.sys_clk(sys_clk), .busyReg(busyReg),
      .frameSync(frameSync), .serialClk(serialClk),
      .serialClkOeReg(serialClkOeReg), .serialDataOut(serialDataOut),
      .serialDataOeReg(serialDataOeReg), .convStartN(convStartN),
      .extSerialClk(extSerialClk), .rxWord(word_rx));
   function automatic logic [15:0] fmt(input logic [15:0] s,
                                       input logic sb);
      fmt = sb ? s : {~s[15], s[14:0]};
   endfunction
   function automatic int lim(input logic [1:0] c);
      lim = c == 2'h0 ? 78 : c == 2'h1 ? 100 : c == 2'h2 ? 144 : 232;
   endfunction
   task automatic chk(input string nm, input logic [15:0] exp,
                      input logic [15:0] got);
      checked++;
      if (exp !== got) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Daisy-chain input is random.
   always @(negedge sys_clk) begin
      serialDataIn <= 1'($urandom);
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      seed = $urandom(44141);
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk) nrst = 1'b1;
      repeat (2) @(negedge sys_clk);
      resetIn = 1'b1;
      repeat (3) @(negedge sys_clk);
      resetIn = 1'b0;
      width = 0;
      @(negedge sys_clk);
      while (busyReg === 1'b1 && width < 300) begin
         width++;
         @(negedge sys_clk);
      end
      chk("resetBusy", 1, width >= 58 && width <= 62);
      repeat (4) @(negedge sys_clk);
      for (int i = 0; i < 6; i++) begin
         smp = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($urandom);
         adcSample = smp;
         straightBinary = i[0];
         i_sac_host_model.conv(80, width);
         chk("parBusy", 1, width >= 1 && width <= 56);
         chipSelN = 1'b0;
         readN = 1'b0;
         @(negedge sys_clk);
         chk("busOe", 1, dataBusOeReg);
         chk("busData", fmt(smp, i[0]), dataBusReg);
         readN = 1'b1;
         @(negedge sys_clk);
         chk("busOff", 0, dataBusOeReg);
         chipSelN = 1'b1;
      end
      i_sac_host_model.conv(50, width);
      i_sac_host_model.pulse();
      chk("earlyStart", 0, busyReg);
      repeat (40) @(negedge sys_clk);
      serialMode = 1'b1;
      chipSelN = 1'b0;
      straightBinary = 1'b1;
      for (int c = 0; c < 4; c++) begin
         smp = 16'($urandom);
         adcSample = smp;
         serialClockDivider = c[1:0];
         i_sac_host_model.conv(80, width);
         chk("acWord", smp, word_rx);
         chk("acBusy", 1, width <= lim(c[1:0]));
      end
      readDuringConv = 1'b1;
      prev = smp;
      smp = 16'($urandom);
      adcSample = smp;
      i_sac_host_model.conv(80, width);
      chk("rdcWord", prev, word_rx);
      chk("rdcBusy", 1, width <= 56);
      extClockMode = 1'b1;
      smp = 16'($urandom);
      adcSample = smp;
      i_sac_host_model.conv(80, width);
      i_sac_host_model.slave_read(word);
      chk("slvWord", smp, word);
      wrap_up();
   end
endmodule // sac_top_tb_top
bind sac_top sac_checker #(.WORD(WORD)) i_sac_checker (.sys_clk(sys_clk),
   .nrst(nrst), .convStartN(convStartN), .resetIn(resetIn),
   .chipSelN(chipSelN), .readN(readN), .serialMode(serialMode),
   .extClockMode(extClockMode), .readDuringConv(readDuringConv),
   .serialClockDivider(serialClockDivider), .busyReg(busyReg),
   .dataBusReg(dataBusReg), .dataBusOeReg(dataBusOeReg),
   .frameSync(frameSync), .frameSyncOeReg(frameSyncOeReg),
   .serialClk(serialClk), .serialClkOeReg(serialClkOeReg),
   .serialDataOeReg(serialDataOeReg),
   .serialClockDividerOutReg(serialClockDividerOutReg),
   .serialClockDividerOeReg(serialClockDividerOeReg));
`default_nettype wire
